// ==== rcs_map.vh ====
// rcs_map.vh: offsets, field positions, reset values and counts
// assumes: included by the reset and clock gate sequencer and by its testbench top
`ifndef RCS_MAP_VH
`define RCS_MAP_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define RCS_OFF_CAUSE 8'h00
`define RCS_OFF_CFG1 8'h04
`define RCS_OFF_CFG2 8'h08
`define RCS_OFF_BRK 8'h0C
`define RCS_OFF_SVC 8'h10
`define RCS_OFF_STAT 8'h14
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RCS_CAUSE_POR 0
`define RCS_CAUSE_PIN 1
`define RCS_CAUSE_WDG 2
`define RCS_CAUSE_BAD_OPCODE_FLAG 3
`define RCS_CAUSE_BAD_FETCH_FLAG 4
`define RCS_CAUSE_LVI 5
`define RCS_CFG1_SHORT_STOP_RECOVERY 0
`define RCS_CFG1_STOPOK 1
`define RCS_CFG2_RESET_PIN_ENABLE 0
`define RCS_BRK_BDWDG 0
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RCS_CAUSE_RST 6'h01
`define RCS_CFG1_RST 2'h0
`define RCS_CFG2_RST 1'h0
`define RCS_BRK_RST 1'h0
// ------------------------------------------------------------
// counts in fast clock cycles, prescaler wrap and mask, reset vectors
// ------------------------------------------------------------
`define RCS_STAB_CYC 4096
`define RCS_PIN_CYC 32
`define RCS_HOLD_CYC 32
`define RCS_TAIL_CYC 3
`define RCS_SREC_SHORT 32
`define RCS_SREC_LONG 4096
`define RCS_PRE_WRAP 13'h0FEF
`define RCS_PRE_SVC_MASK 13'h001F
`define RCS_VEC_USER 16'hFFFE
`define RCS_VEC_MON 16'hFEFE
`endif

// ==== rcs_sequencer.v ====
// rcs_sequencer.v: reset and clock gate sequencer with apb registers
// assumes: i_clk is the fast oscillator clock; cpu and modules obey
// o_int_rst and the clock enables; pin and lvi inputs are asynchronous
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "rcs_map.vh"
module rcs_sequencer #(
  parameter WDG_BITS = 6,
  parameter MIN_PULSE = 4,
  parameter STAB_CYC = `RCS_STAB_CYC,
  parameter SREC_LONG = `RCS_SREC_LONG
)(
  // clock and power-on reset
  input wire i_clk,
  input wire i_rst_b,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // reset pin and analog monitor
  input wire i_rst_pin,
  input wire i_lvi,
  output reg o_rst_pin_out,
  output reg o_rst_pin_oe,
  output reg o_gpio_in,
  // cpu status
  input wire i_illegal_op,
  input wire i_stop_exec,
  input wire i_wait_exec,
  input wire i_opcode_fetch,
  input wire i_unmapped,
  input wire i_wake,
  input wire i_monitor,
  input wire i_break,
  // reset and clock controls
  output reg o_int_rst,
  output reg [15:0] o_vector,
  output reg o_osc_en,
  output reg o_cpu_clk_en,
  output reg o_per_clk_en,
  output reg o_bus_tick
);
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam S_STAB = 4'h0;
  localparam S_PIN = 4'h1;
  localparam S_HOLD = 4'h2;
  localparam S_TAIL = 4'h3;
  localparam S_RUN = 4'h4;
  localparam S_EXT = 4'h5;
  localparam S_LVI = 4'h6;
  localparam S_STOP = 4'h7;
  localparam S_SREC = 4'h8;
  localparam S_WAIT = 4'h9;
  localparam [12:0] STAB_LAST = STAB_CYC - 1;
  localparam [12:0] SREC_LAST = SREC_LONG - 1;
  localparam [12:0] SHORT_LAST = `RCS_SREC_SHORT - 1;
  localparam [12:0] PIN_LAST = `RCS_PIN_CYC - 1;
  localparam [12:0] HOLD_LAST = `RCS_HOLD_CYC - 1;
  localparam [12:0] TAIL_LAST = `RCS_TAIL_CYC - 1;
  localparam [12:0] MIN_LAST = MIN_PULSE - 1;

  reg [3:0] state;
  reg [3:0] next_state;
  reg [12:0] cnt;
  reg [12:0] next_cnt;
  reg from_ext;
  reg next_from_ext;
  reg [5:0] cause;
  reg [1:0] cfg1;
  reg cfg2;
  reg brk_aux;
  reg svc;
  reg pre_clr;
  reg [12:0] pre;
  reg pre_tick;
  reg [WDG_BITS-1:0] wdg;
  reg wdg_req;
  reg [1:0] div;
  reg [2:0] pin_sync;
  reg [2:0] lvi_sync;
  reg pin_lvl;
  reg lvi_lvl;

  // ------------------------------------------------------------
  // synchronisers: change counts when stages two and three agree
  // ------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pin_sync <= 3'h7;
      lvi_sync <= 3'h0;
      pin_lvl <= 1'b1;
      lvi_lvl <= 1'b0;
    end
    else
    begin
      pin_sync <= {pin_sync[1:0], i_rst_pin};
      lvi_sync <= {lvi_sync[1:0], i_lvi};
      if (pin_sync[1] == pin_sync[2])
        pin_lvl <= pin_sync[2];
      if (lvi_sync[1] == lvi_sync[2])
        lvi_lvl <= lvi_sync[2];
    end
  end

  // ------------------------------------------------------------
  // reset source decode
  // ------------------------------------------------------------
  wire running = (state == S_RUN);
  wire cpu_live = running || (state == S_WAIT);
  // own pin drive and its sync lag must not pass for an outside reset
  wire own_drive = (state == S_LVI) || (!from_ext && (state == S_PIN || state == S_HOLD));
  wire ext_low = cfg2 && !pin_lvl && !own_drive;
  wire bad_opcode_flag_ev = running && (i_illegal_op || (i_stop_exec && !cfg1[`RCS_CFG1_STOPOK]));
  wire bad_fetch_flag_ev = running && i_opcode_fetch && i_unmapped;
  wire wdg_ev = cpu_live && wdg_req;
  wire int_ev = bad_opcode_flag_ev || bad_fetch_flag_ev || wdg_ev;
  wire stop_go = running && i_stop_exec && cfg1[`RCS_CFG1_STOPOK];
  wire [12:0] srec_last = cfg1[`RCS_CFG1_SHORT_STOP_RECOVERY] ? SHORT_LAST : SREC_LAST;
  wire pin_flag_ev = (state == S_EXT) && (cnt == MIN_LAST);

  // ------------------------------------------------------------
  // sequencer next state
  // ------------------------------------------------------------
  always @*
  begin
    next_state = state;
    next_cnt = cnt + 13'h0001;
    next_from_ext = from_ext;
    case (state)
      S_STAB:
        if (cnt == STAB_LAST)
        begin
          next_state = S_PIN;
          next_cnt = 13'h0000;
        end
      S_PIN:
        if (cnt == PIN_LAST)
        begin
          next_state = S_HOLD;
          next_cnt = 13'h0000;
        end
      S_HOLD:
        if (cnt == HOLD_LAST)
        begin
          next_state = S_TAIL;
          next_cnt = 13'h0000;
        end
      S_TAIL:
        if (cnt == TAIL_LAST)
        begin
          next_state = S_RUN;
          next_cnt = 13'h0000;
          next_from_ext = 1'b0;
        end
      S_EXT:
      begin
        if (cnt == MIN_LAST)
          next_cnt = cnt;
        if (!ext_low)
        begin
          next_state = S_PIN;
          next_cnt = 13'h0000;
        end
      end
      S_LVI:
      begin
        next_cnt = 13'h0000;
        if (!lvi_lvl)
          next_state = S_STAB;
      end
      S_STOP:
      begin
        next_cnt = 13'h0000;
        if (i_wake)
          next_state = S_SREC;
      end
      S_SREC:
        if (cnt == srec_last)
        begin
          next_state = S_RUN;
          next_cnt = 13'h0000;
        end
      S_WAIT:
      begin
        next_cnt = 13'h0000;
        if (i_wake)
          next_state = S_RUN;
      end
      default:
      begin
        next_cnt = 13'h0000;
        if (stop_go)
          next_state = S_STOP;
        else if (i_wait_exec)
          next_state = S_WAIT;
      end
    endcase
    // reset sources override the walk above
    if (state != S_STAB && state != S_EXT && ext_low)
    begin
      next_state = S_EXT;
      next_cnt = 13'h0000;
      next_from_ext = 1'b1;
    end
    else if (int_ev)
    begin
      next_state = S_PIN;
      next_cnt = 13'h0000;
      next_from_ext = 1'b0;
    end
    if (lvi_lvl && state != S_LVI)
    begin
      next_state = S_LVI;
      next_cnt = 13'h0000;
      next_from_ext = 1'b0;
    end
  end

  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state <= S_STAB;
      cnt <= 13'h0000;
      from_ext <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      from_ext <= next_from_ext;
    end
  end

  // ------------------------------------------------------------
  // prescaler on the falling edge
  // ------------------------------------------------------------
  always @(negedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pre <= 13'h0000;
      pre_tick <= 1'b0;
    end
    else if (pre_clr)
    begin
      pre <= 13'h0000;
      pre_tick <= 1'b0;
    end
    else
    begin
      pre_tick <= (pre == `RCS_PRE_WRAP);
      if (svc)
        pre <= pre & `RCS_PRE_SVC_MASK;
      else if (pre == `RCS_PRE_WRAP)
        pre <= 13'h0000;
      else
        pre <= pre + 13'h0001;
    end
  end

  // ------------------------------------------------------------
  // watchdog counter
  // ------------------------------------------------------------
  wire wdg_hold = i_break && i_monitor && brk_aux;
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wdg <= {WDG_BITS{1'b0}};
      wdg_req <= 1'b0;
      pre_clr <= 1'b0;
    end
    else
    begin
      pre_clr <= (next_state == S_STOP) ||
        (!next_from_ext && (next_state == S_STAB || next_state == S_PIN || next_state == S_LVI));
      if (o_int_rst || svc)
      begin
        wdg <= {WDG_BITS{1'b0}};
        wdg_req <= 1'b0;
      end
      else if (pre_tick && !wdg_hold)
      begin
        wdg <= wdg + {{(WDG_BITS-1){1'b0}}, 1'b1};
        wdg_req <= &wdg;
      end
    end
  end

  // ------------------------------------------------------------
  // apb registers
  // ------------------------------------------------------------
  wire acc = i_psel && i_penable && o_pready;
  wire wr = acc && i_pwrite;
  wire hit = (i_paddr == `RCS_OFF_CAUSE) || (i_paddr == `RCS_OFF_CFG1) ||
    (i_paddr == `RCS_OFF_CFG2) || (i_paddr == `RCS_OFF_BRK) ||
    (i_paddr == `RCS_OFF_SVC) || (i_paddr == `RCS_OFF_STAT);
  wire [5:0] cause_set = {lvi_lvl && state != S_LVI, bad_fetch_flag_ev, bad_opcode_flag_ev, wdg_ev, pin_flag_ev, 1'b0};
  wire [5:0] cause_clr = (wr && i_paddr == `RCS_OFF_CAUSE) ? i_pwdata[5:0] : 6'h00;

  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cause <= `RCS_CAUSE_RST;
      cfg1 <= `RCS_CFG1_RST;
      cfg2 <= `RCS_CFG2_RST;
      brk_aux <= `RCS_BRK_RST;
      svc <= 1'b0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end
    else
    begin
      cause <= (cause & ~cause_clr) | cause_set;
      svc <= wr && (i_paddr == `RCS_OFF_SVC);
      if (wr && i_paddr == `RCS_OFF_CFG1)
        cfg1 <= i_pwdata[1:0];
      if (wr && i_paddr == `RCS_OFF_CFG2)
        cfg2 <= i_pwdata[`RCS_CFG2_RESET_PIN_ENABLE];
      if (wr && i_paddr == `RCS_OFF_BRK)
        brk_aux <= i_pwdata[`RCS_BRK_BDWDG];
      o_pready <= i_psel && i_penable && !o_pready;
      o_pslverr <= i_psel && i_penable && !o_pready && !hit;
      o_prdata <= 32'h00000000;
      if (i_psel && i_penable && !o_pready && !i_pwrite)
      begin
        case (i_paddr)
          `RCS_OFF_CAUSE: o_prdata <= {26'h0000000, cause};
          `RCS_OFF_CFG1: o_prdata <= {30'h00000000, cfg1};
          `RCS_OFF_CFG2: o_prdata <= {31'h00000000, cfg2};
          `RCS_OFF_BRK: o_prdata <= {31'h00000000, brk_aux};
          `RCS_OFF_STAT: o_prdata <= {25'h0000000, lvi_lvl, pin_lvl, from_ext, state};
          default: o_prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // registered control outputs
  // ------------------------------------------------------------
  wire n_rst = (next_state == S_STAB) || (next_state == S_PIN) || (next_state == S_HOLD) ||
    (next_state == S_TAIL) || (next_state == S_EXT) || (next_state == S_LVI);
  wire n_drive = cfg2 && ((next_state == S_STAB) || (next_state == S_LVI) ||
    (next_state == S_PIN && !next_from_ext));
  wire n_cpu = (next_state == S_PIN) || (next_state == S_HOLD) ||
    (next_state == S_TAIL) || (next_state == S_RUN) || (next_state == S_EXT);
  wire n_per = n_cpu || (next_state == S_WAIT);

  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_int_rst <= 1'b1;
      o_rst_pin_out <= 1'b0;
      o_rst_pin_oe <= 1'b0;
      o_gpio_in <= 1'b1;
      o_vector <= `RCS_VEC_USER;
      o_osc_en <= 1'b1;
      o_cpu_clk_en <= 1'b0;
      o_per_clk_en <= 1'b0;
      o_bus_tick <= 1'b0;
      div <= 2'h0;
    end
    else
    begin
      o_int_rst <= n_rst;
      o_rst_pin_out <= 1'b0;
      o_rst_pin_oe <= n_drive;
      o_gpio_in <= pin_lvl;
      o_vector <= i_monitor ? `RCS_VEC_MON : `RCS_VEC_USER;
      o_osc_en <= (next_state != S_STOP);
      o_cpu_clk_en <= n_cpu;
      o_per_clk_en <= n_per;
      div <= div + 2'h1;
      o_bus_tick <= (div == 2'h3) && n_cpu;
    end
  end
endmodule

// ==== rcs_sequencer_properties.sv ====
// rcs_sequencer_properties.sv: port timing checks for the sequencer
// assumes: bound to rcs_sequencer, one clock domain
`timescale 1ns/1ns
module rcs_seq_chk (
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // cpu and analog inputs
  input wire i_illegal_op,
  input wire i_wait_exec,
  input wire i_opcode_fetch,
  input wire i_unmapped,
  input wire i_lvi,
  input wire i_monitor,
  // outputs watched
  input wire o_int_rst,
  input wire [15:0] o_vector,
  input wire o_osc_en,
  input wire o_cpu_clk_en,
  input wire o_per_clk_en,
  input wire o_bus_tick,
  input wire o_rst_pin_oe
);
  logic [15:0] n_oe;
  logic [15:0] n_rst;
  logic drv;
  // ----------------------------------------
  // span counters
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      n_oe <= 16'h0000;
      n_rst <= 16'h0000;
      drv <= 1'h0;
    end
    else
    begin
      n_oe <= o_rst_pin_oe ? n_oe + 16'h0001 : 16'h0000;
      n_rst <= o_int_rst ? n_rst + 16'h0001 : 16'h0000;
      drv <= o_int_rst & (drv | o_rst_pin_oe);
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_vec_mode: assert property (o_vector == ($past(i_monitor) ? 16'hFEFE : 16'hFFFE))
    else $error("vector mismatch");
  a_badop_rst: assert property (!o_int_rst && o_cpu_clk_en && i_illegal_op |=> o_int_rst)
    else $error("bad opcode no reset");
  a_fetch_rst: assert property (!o_int_rst && o_cpu_clk_en && i_opcode_fetch && i_unmapped |=> o_int_rst)
    else $error("bad fetch no reset");
  a_pin_span: assert property ($fell(o_rst_pin_oe) |-> n_oe == 16'h0020)
    else $error("pin drive span wrong");
  a_rst_span: assert property ($fell(o_int_rst) && drv |-> n_rst == 16'h0043)
    else $error("reset span wrong");
  a_wait_gate: assert property (!o_int_rst && o_cpu_clk_en && i_wait_exec && !i_illegal_op
    |-> ##[1:2] (!o_cpu_clk_en && o_per_clk_en))
    else $error("wait gating wrong");
  a_stop_gate: assert property (!o_osc_en |-> !o_cpu_clk_en && !o_per_clk_en)
    else $error("clocks run in stop");
  a_tick_rate: assert property (o_bus_tick |=> !o_bus_tick [*3])
    else $error("bus tick too fast");
  a_lvi_hold: assert property (i_lvi [*8] |-> o_int_rst && !o_cpu_clk_en)
    else $error("low supply not held");
  a_osc_rst: assert property (o_int_rst |-> o_osc_en)
    else $error("oscillator off in reset");
endmodule

bind rcs_sequencer rcs_seq_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_illegal_op(i_illegal_op),
  .i_wait_exec(i_wait_exec), .i_opcode_fetch(i_opcode_fetch), .i_unmapped(i_unmapped), .i_lvi(i_lvi),
  .i_monitor(i_monitor), .o_int_rst(o_int_rst), .o_vector(o_vector), .o_osc_en(o_osc_en),
  .o_cpu_clk_en(o_cpu_clk_en), .o_per_clk_en(o_per_clk_en), .o_bus_tick(o_bus_tick),
  .o_rst_pin_oe(o_rst_pin_oe));

// ==== rcs_far_side.sv ====
// rcs_far_side.sv: cpu status pulses and the shared reset pin wire
// assumes: pulse is called right after a rising edge
`timescale 1ns/1ns
module rcs_far_side (
  // clock
  input wire i_clk,
  // pin drivers
  input wire i_pin_oe,
  input wire i_pin_out,
  input wire i_ext_low,
  // resolved pin and cpu status
  output wire o_pin,
  output logic [5:0] o_ev
);
  initial o_ev = 6'h00;
  // pull-up unless a party drives low
  assign o_pin = (i_pin_oe ? i_pin_out : 1'h1) & !i_ext_low;
  // bits: bad op, stop, wait, fetch, unmapped, wake
  task automatic pulse(input logic [5:0] m);
    o_ev <= m;
    @(posedge i_clk);
    o_ev <= 6'h00;
  endtask
endmodule

// ==== rcs_sequencer_tb_top.sv ====
// rcs_sequencer_tb_top.sv: directed scenarios for the sequencer
// assumes: rcs_map.vh on the include path, far side model and checker compiled
`timescale 1ns/1ns
`include "rcs_map.vh"
module rcs_sequencer_tb_top;
  localparam int STAB = 64;
  logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic low_voltage_flag = 1'h0, mon = 1'h0, ext_low = 1'h0, brk = 1'h0, rerr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdat;
  wire [31:0] prdata;
  wire [15:0] vec;
  wire [5:0] ev;
  wire pready, pslverr, pin, pin_out, oe, gpio, int_rst, osc, cpu_en, per_en;
  int cyc, compares = 0, n_mismatch = 0;
  always #2 clk = ~clk;
  rcs_far_side far (.i_clk(clk), .i_pin_oe(oe), .i_pin_out(pin_out), .i_ext_low(ext_low), .o_pin(pin),
    .o_ev(ev));
  rcs_sequencer #(.WDG_BITS(2), .MIN_PULSE(4), .STAB_CYC(STAB), .SREC_LONG(64)) DUT (.i_clk(clk),
    .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rst_pin(pin),
    .i_lvi(low_voltage_flag), .o_rst_pin_out(pin_out), .o_rst_pin_oe(oe), .o_gpio_in(gpio), .i_illegal_op(ev[0]),
    .i_stop_exec(ev[1]), .i_wait_exec(ev[2]), .i_opcode_fetch(ev[3]), .i_unmapped(ev[4]), .i_wake(ev[5]),
    .i_monitor(mon), .i_break(brk), .o_int_rst(int_rst), .o_vector(vec), .o_osc_en(osc),
    .o_cpu_clk_en(cpu_en), .o_per_clk_en(per_en), .o_bus_tick());
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cause(input logic [5:0] e);
    apb(1'h0, `RCS_OFF_CAUSE, 32'h0);
    chk(rdat, {26'h0, e});
    apb(1'h1, `RCS_OFF_CAUSE, 32'h3F);
  endtask
  task automatic settle;
    cyc = 0;
    do
    begin
      @(negedge clk);
      cyc++;
    end
    while (int_rst !== 1'h0 && cyc < 9000);
    if (int_rst !== 1'h0) n_mismatch++;
  endtask
  task automatic hit(input logic [5:0] m);
    @(posedge clk);
    far.pulse(m);
    @(posedge clk);
    @(negedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_por;
    @(negedge clk);
    chk({cpu_en, per_en, osc, oe}, 4'h2);
    settle;
    chk(cyc, STAB + 67);
    chk(vec, 16'hFFFE);
    cause(6'h01);
    for (logic [7:0] a = 8'h04; a < 8'h10; a += 8'h04)
    begin
      apb(1'h0, a, 32'h0);
      chk(rdat, 32'h0);
    end
    apb(1'h0, 8'h18, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1);
  endtask
  task automatic t_int;
    logic [5:0] m [3] = '{6'h01, 6'h02, 6'h18};
    hit(6'h10);
    chk(int_rst, 1'h0);
    apb(1'h1, `RCS_OFF_CFG2, 32'h1);
    for (int k = 0; k < 3; k++)
    begin
      mon <= (k == 1);
      hit(m[k]);
      chk({int_rst, oe}, 2'h3);
      settle;
      chk(vec, (k == 1) ? 16'hFEFE : 16'hFFFE);
      cause((k == 2) ? 6'h10 : 6'h08);
    end
    mon <= 1'h0;
  endtask
  task automatic t_gate;
    logic [31:0] c [2] = '{32'h3, 32'h2};
    hit(6'h04);
    chk({cpu_en, per_en}, 2'h1);
    hit(6'h20);
    for (int k = 0; k < 2; k++)
    begin
      apb(1'h1, `RCS_OFF_CFG1, c[k]);
      hit(6'h02);
      chk({osc, cpu_en, per_en}, 3'h0);
      hit(6'h20);
      cyc = 0;
      while (cpu_en !== 1'h1 && cyc < 200)
      begin
        @(negedge clk);
        cyc++;
      end
      chk(cyc >= 32 * (k + 1) - 2 && cyc <= 32 * (k + 1) + 4, 1'h1);
    end
  endtask
  task automatic t_wdg;
    logic seen = 1'h0;
    apb(1'h1, `RCS_OFF_SVC, 32'h5A);
    repeat (16000)
    begin
      @(negedge clk);
      seen |= int_rst;
    end
    chk(seen, 1'h0);
    cyc = 0;
    while (int_rst !== 1'h1 && cyc < 600)
    begin
      @(negedge clk);
      cyc++;
    end
    chk(int_rst, 1'h1);
    settle;
    cause(6'h04);
  endtask
  task automatic t_lvi;
    apb(1'h1, `RCS_OFF_CFG2, 32'h0);
    low_voltage_flag <= 1'h1;
    repeat (20) @(negedge clk);
    chk({int_rst, cpu_en, oe}, 3'h4);
    @(posedge clk);
    low_voltage_flag <= 1'h0;
    settle;
    // four sync edges, one state edge and one settle edge on top
    chk(cyc, STAB + 73);
    cause(6'h20);
  endtask
  task automatic t_pin;
    ext_low <= 1'h1;
    repeat (8) @(negedge clk);
    chk({int_rst, gpio}, 2'h0);
    @(posedge clk);
    ext_low <= 1'h0;
    repeat (4) @(posedge clk);
    apb(1'h1, `RCS_OFF_CFG2, 32'h1);
    ext_low <= 1'h1;
    repeat (12) @(negedge clk);
    chk({int_rst, cpu_en}, 2'h3);
    @(posedge clk);
    ext_low <= 1'h0;
    settle;
    cause(6'h02);
  endtask
  task automatic t_brk;
    logic seen = 1'h0;
    apb(1'h1, `RCS_OFF_BRK, 32'h1);
    mon <= 1'h1;
    brk <= 1'h1;
    apb(1'h1, `RCS_OFF_SVC, 32'h0);
    // longer than four prescaler wraps: a live watchdog would bite
    repeat (17000)
    begin
      @(negedge clk);
      seen |= int_rst;
    end
    chk(seen, 1'h0);
    @(posedge clk);
    brk <= 1'h0;
    mon <= 1'h0;
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    conclude;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    t_por;
    t_int;
    t_gate;
    t_wdg;
    t_lvi;
    t_pin;
    t_brk;
    conclude;
  end
endmodule
